// ==== core/alu_defines.svh ====
// register offsets, field positions, reset values and cycle counts
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH
`define ALU_OFS_CMD    5'h00
`define ALU_OFS_ACC    5'h04
`define ALU_OFS_OPND   5'h08
`define ALU_OFS_FLAGS  5'h0c
`define ALU_OFS_SHCNT  5'h10
`define ALU_OFS_STAT   5'h14
`define ALU_STAT_CYC_LSB 8
`define ALU_RST_WORD   32'h0000_0000
`define ALU_CYC_INC_B  6'd2
`define ALU_CYC_DEC_B  6'd3
`define ALU_CYC_IND_W  6'd3
`define ALU_CYC_IND_L  6'd7
`define ALU_CYC_CMP_A  6'd1
`define ALU_CYC_CMP_R  6'd2
`define ALU_CYC_CMP_L  6'd6
`define ALU_CYC_DVA_Z  6'd3
`define ALU_CYC_DVA_O  6'd7
`define ALU_CYC_DVA_N  6'd15
`define ALU_CYC_DVR_Z  6'd4
`define ALU_CYC_DVR_O  6'd8
`define ALU_CYC_DVR_N  6'd16
`define ALU_CYC_DVW_Z  6'd4
`define ALU_CYC_DVW_O  6'd7
`define ALU_CYC_DVW_N  6'd22
`define ALU_CYC_MLA_Z  6'd3
`define ALU_CYC_MLA_N  6'd7
`define ALU_CYC_MLR_Z  6'd4
`define ALU_CYC_MLR_N  6'd8
`define ALU_CYC_MWA_Z  6'd3
`define ALU_CYC_MWA_N  6'd11
`define ALU_CYC_MWR_Z  6'd4
`define ALU_CYC_MWR_N  6'd12
`define ALU_CYC_UN_A   6'd2
`define ALU_CYC_UN_R   6'd3
`define ALU_CYC_LOG_L  6'd6
`define ALU_CYC_NRM_Z  6'd4
`define ALU_CYC_NRM_B  6'd6
`endif

// ==== core/alu_pkg.sv ====
// types shared by the arithmetic/logic datapath
package alu_pkg;
	typedef enum logic [3:0] {
		OP_ADD_ONE = 4'h0, OP_SUB_ONE = 4'h1, OP_COMPARE = 4'h2,
		OP_QUOT = 4'h3, OP_QUOT_WIDE = 4'h4, OP_PROD = 4'h5,
		OP_PROD_WIDE = 4'h6, OP_AND = 4'h7, OP_OR = 4'h8,
		OP_XOR = 4'h9, OP_INVERT = 4'ha, OP_TWOS = 4'hb,
		OP_NORM = 4'hc
	} alu_op_type;
	typedef enum logic [1:0] {
		W_BYTE = 2'h0, W_WORD = 2'h1, W_LONG = 2'h2
	} alu_width_type;
	typedef enum logic [1:0] {
		F_ACC = 2'h0, F_REG = 2'h1, F_MEM = 2'h2
	} alu_form_type;
	typedef struct packed {
		alu_form_type  form;
		alu_width_type width;
		alu_op_type    op;
	} alu_cmd_type;
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} alu_flags_type;
	typedef struct packed {
		logic [4:0]  addr;
		logic        rd;
		logic        wr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} alu_avreq_type;
	typedef struct packed {
		logic [31:0]   acc;
		logic [31:0]   opnd;
		alu_flags_type flg;
		logic [7:0]    shcnt;
		alu_cmd_type   cmd;
		logic          busy;
		logic [5:0]    cnt;
		logic [5:0]    cyc;
		logic          waitreq;
		logic [31:0]   rdata;
	} alu_state_type;
endpackage : alu_pkg

// ==== core/alu_datapath.sv ====
// arithmetic/logic datapath with an avalon-mm register slave
// Behaviour
// - add_one/sub_one change by one, carry kept
// - long add_one/sub_one on register: 7 cycles
// - compare subtracts, writes nothing, sets flags
// - byte quotient: top word by bottom byte on accumulator, low word by operand byte on register
// - wide quotient: long by word, remainder out
// - accumulator byte quotient: 3, 7, 15 cycles
// - register byte quotient: 4, 8, 16 cycles
// - wide quotient on register: 4, 7, 22
// - accumulator wide product: 3 or 11 cycles
// - logic ops set n, z; clear v
// - word accumulator logic: top with low word
// - invert complements operand, sets n, z
// - long logic with register: 6 cycles
// - twos complement is zero minus operand
// - normalize: 4 if zero, else 6+shift
`timescale 1ns/1ps
`include "alu_defines.svh"
module alu_datapath
	import alu_pkg::*;
(
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_I,
	input  wire logic [4:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	output logic             BUSY_O
);
	alu_state_type s_r;
	alu_state_type s_nxt;
	alu_avreq_type req;
	alu_cmd_type   lcmd;
	logic          launch;

	function automatic logic [31:0] wmask(input alu_width_type w);
		unique case (w)
			W_BYTE: wmask = 32'h0000_00ff;
			W_WORD: wmask = 32'h0000_ffff;
			default: wmask = 32'hffff_ffff;
		endcase
	endfunction : wmask

	function automatic logic topbit(input alu_width_type w,
		input logic [31:0] v);
		unique case (w)
			W_BYTE: topbit = v[7];
			W_WORD: topbit = v[15];
			default: topbit = v[31];
		endcase
	endfunction : topbit

	function automatic alu_flags_type subflg(input alu_width_type w,
		input logic [31:0] a, input logic [31:0] b);
		logic [31:0] r;
		r = (a - b) & wmask(w);
		subflg.n = topbit(w, r);
		subflg.z = (r == 32'h0);
		subflg.v = (topbit(w, a) ^ topbit(w, b)) &
			(topbit(w, a) ^ topbit(w, r));
		subflg.c = (a < b);
	endfunction : subflg

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : o[i*8 +: 8];
		end
	endfunction : merge

	function automatic logic [5:0] lead0(input logic [31:0] v);
		lead0 = 6'h0;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) begin
				lead0 = 6'(31 - i);
			end
		end
	endfunction : lead0

	assign req = '{addr: AVS_ADDRESS_I, rd: AVS_READ_I,
		wr: AVS_WRITE_I, wdata: AVS_WRITEDATA_I,
		be: AVS_BYTEENABLE_I};
	assign lcmd = alu_cmd_type'(req.wdata[7:0]);
	assign launch = req.wr & ~s_r.waitreq & req.be[0] &
		(req.addr == `ALU_OFS_CMD);

	always_comb begin
		logic [31:0] m;
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] r;
		logic [15:0] dd;
		logic [7:0]  dv;
		logic [31:0] dl;
		logic [15:0] dw;
		logic        ovf;
		logic        zer;
		logic [5:0]  cy;
		s_nxt = s_r;
		m = wmask(lcmd.width);
		x = 32'h0;
		y = 32'h0;
		r = 32'h0;
		dd = 16'h0;
		dv = 8'h0;
		dl = 32'h0;
		dw = 16'h0;
		ovf = 1'b0;
		zer = 1'b0;
		cy = 6'd1;
		if (s_r.busy) begin
			if (s_r.cnt == 6'd0) begin
				s_nxt.busy = 1'b0;
			end else begin
				s_nxt.cnt = s_r.cnt - 6'd1;
			end
		end
		// answer one cycle after a request seen while idle
		s_nxt.waitreq = 1'b1;
		if ((req.rd | req.wr) & s_r.waitreq & ~s_r.busy) begin
			s_nxt.waitreq = 1'b0;
			unique case (req.addr)
				`ALU_OFS_CMD:   s_nxt.rdata = {24'h0, s_r.cmd};
				`ALU_OFS_ACC:   s_nxt.rdata = s_r.acc;
				`ALU_OFS_OPND:  s_nxt.rdata = s_r.opnd;
				`ALU_OFS_FLAGS: s_nxt.rdata = {28'h0, s_r.flg};
				`ALU_OFS_SHCNT: s_nxt.rdata = {24'h0, s_r.shcnt};
				`ALU_OFS_STAT:  s_nxt.rdata = {18'h0, s_r.cyc,
					7'h0, s_r.busy};
				default:        s_nxt.rdata = 32'h0;
			endcase
		end
		if (req.wr & ~s_r.waitreq) begin
			unique case (req.addr)
				`ALU_OFS_ACC:   s_nxt.acc = merge(s_r.acc, req.wdata,
					req.be);
				`ALU_OFS_OPND:  s_nxt.opnd = merge(s_r.opnd, req.wdata,
					req.be);
				`ALU_OFS_FLAGS: if (req.be[0]) begin
					s_nxt.flg = alu_flags_type'(req.wdata[3:0]);
				end
				`ALU_OFS_SHCNT: if (req.be[0]) begin
					s_nxt.shcnt = req.wdata[7:0];
				end
				default: ;
			endcase
		end
		// one operation per command write; the bus stalls until done,
		// so a memory-form update is never split by another access
		// atomic update
		if (launch) begin
			s_nxt.cmd = lcmd;
			x = (lcmd.form == F_ACC) ? s_r.acc : s_r.opnd;
			unique case (lcmd.op)
				OP_ADD_ONE, OP_SUB_ONE: begin
					r = (lcmd.op == OP_ADD_ONE) ? x + 32'h1 : x - 32'h1;
					r = r & m;
					s_nxt.flg.n = topbit(lcmd.width, r);
					s_nxt.flg.z = (r == 32'h0);
					s_nxt.flg.v = (lcmd.op == OP_ADD_ONE) ?
						~topbit(lcmd.width, x) & topbit(lcmd.width, r) :
						topbit(lcmd.width, x) & ~topbit(lcmd.width, r);
					if (lcmd.form == F_ACC) begin
						s_nxt.acc = (s_r.acc & ~m) | r;
					end else begin
						s_nxt.opnd = (s_r.opnd & ~m) | r;
					end
					if (lcmd.width == W_LONG) begin
						cy = `ALU_CYC_IND_L;
					end else if (lcmd.width == W_WORD) begin
						cy = `ALU_CYC_IND_W;
					end else begin
						cy = (lcmd.op == OP_ADD_ONE) ? `ALU_CYC_INC_B :
							`ALU_CYC_DEC_B;
					end
				end
				OP_COMPARE: begin
					if (lcmd.form == F_ACC && lcmd.width != W_LONG) begin
						x = (lcmd.width == W_BYTE) ? {24'h0, s_r.acc[23:16]}
							: {16'h0, s_r.acc[31:16]};
						cy = `ALU_CYC_CMP_A;
					end else begin
						x = s_r.acc & m;
						cy = (lcmd.width == W_LONG) ? `ALU_CYC_CMP_L :
							`ALU_CYC_CMP_R;
					end
					y = (lcmd.form == F_ACC && lcmd.width != W_LONG) ?
						s_r.acc & m : s_r.opnd & m;
					s_nxt.flg = subflg(lcmd.width, x, y);
				end
				OP_QUOT: begin
					dd = (lcmd.form == F_ACC) ? s_r.acc[31:16] :
						s_r.acc[15:0];
					dv = (lcmd.form == F_ACC) ? s_r.acc[7:0] : s_r.opnd[7:0];
					ovf = (dv == 8'h0) || (dd[15:8] >= dv);
					zer = ~ovf && (dd < {8'h0, dv});
					s_nxt.flg.v = ovf;
					s_nxt.flg.c = (dv == 8'h0);
					if (!ovf) begin
						r[15:0] = dd / {8'h0, dv};
						y[15:0] = dd % {8'h0, dv};
						if (lcmd.form == F_ACC) begin
							s_nxt.acc[15:0] = {y[7:0], r[7:0]};
						end else begin
							s_nxt.acc[7:0] = r[7:0];
							s_nxt.opnd[7:0] = y[7:0];
						end
					end
					if (lcmd.form == F_ACC) begin
						cy = zer ? `ALU_CYC_DVA_Z : ovf ? `ALU_CYC_DVA_O :
							`ALU_CYC_DVA_N;
					end else begin
						cy = zer ? `ALU_CYC_DVR_Z : ovf ? `ALU_CYC_DVR_O :
							`ALU_CYC_DVR_N;
					end
				end
				OP_QUOT_WIDE: begin
					dl = s_r.acc;
					dw = s_r.opnd[15:0];
					ovf = (dw == 16'h0) || (dl[31:16] >= dw);
					zer = ~ovf && (dl < {16'h0, dw});
					s_nxt.flg.v = ovf;
					s_nxt.flg.c = (dw == 16'h0);
					if (!ovf) begin
						r = dl / {16'h0, dw};
						y = dl % {16'h0, dw};
						s_nxt.acc = {16'h0, r[15:0]};
						s_nxt.opnd[15:0] = y[15:0];
					end
					cy = zer ? `ALU_CYC_DVW_Z : ovf ? `ALU_CYC_DVW_O :
						`ALU_CYC_DVW_N;
				end
				OP_PROD: begin
					x[7:0] = (lcmd.form == F_ACC) ? s_r.acc[23:16] :
						s_r.acc[7:0];
					y[7:0] = (lcmd.form == F_ACC) ? s_r.acc[7:0] :
						s_r.opnd[7:0];
					s_nxt.acc[15:0] = 16'(x[7:0]) * 16'(y[7:0]);
					if (lcmd.form == F_ACC) begin
						cy = (x[7:0] == 8'h0) ? `ALU_CYC_MLA_Z : `ALU_CYC_MLA_N;
					end else begin
						cy = (y[7:0] == 8'h0) ? `ALU_CYC_MLR_Z : `ALU_CYC_MLR_N;
					end
				end
				OP_PROD_WIDE: begin
					x[15:0] = (lcmd.form == F_ACC) ? s_r.acc[31:16] :
						s_r.acc[15:0];
					y[15:0] = (lcmd.form == F_ACC) ? s_r.acc[15:0] :
						s_r.opnd[15:0];
					s_nxt.acc = 32'(x[15:0]) * 32'(y[15:0]);
					if (lcmd.form == F_ACC) begin
						cy = (x[15:0] == 16'h0) ? `ALU_CYC_MWA_Z :
							`ALU_CYC_MWA_N;
					end else begin
						cy = (y[15:0] == 16'h0) ? `ALU_CYC_MWR_Z :
							`ALU_CYC_MWR_N;
					end
				end
				OP_AND, OP_OR, OP_XOR: begin
					x = s_r.acc;
					y = s_r.opnd;
					cy = `ALU_CYC_UN_R;
					if (lcmd.form == F_ACC && lcmd.width == W_WORD) begin
						x = {16'h0, s_r.acc[31:16]};
						y = s_r.acc;
						cy = `ALU_CYC_UN_A;
					end
					unique case (lcmd.op)
						OP_AND: r = (x & y) & m;
						OP_OR:  r = (x | y) & m;
						default: r = (x ^ y) & m;
					endcase
					s_nxt.flg.n = topbit(lcmd.width, r);
					s_nxt.flg.z = (r == 32'h0);
					s_nxt.flg.v = 1'b0;
					if (lcmd.width == W_LONG) begin
						s_nxt.acc = r;
						cy = `ALU_CYC_LOG_L;
					end else if (lcmd.form == F_MEM) begin
						s_nxt.opnd = (s_r.opnd & ~m) | r;
					end else begin
						s_nxt.acc = (s_r.acc & ~m) | r;
					end
				end
				OP_INVERT, OP_TWOS: begin
					r = (lcmd.op == OP_INVERT) ? ~x & m : (32'h0 - x) & m;
					if (lcmd.op == OP_TWOS) begin
						s_nxt.flg = subflg(lcmd.width, 32'h0, x & m);
					end else begin
						s_nxt.flg.n = topbit(lcmd.width, r);
						s_nxt.flg.z = (r == 32'h0);
						s_nxt.flg.v = 1'b0;
					end
					if (lcmd.form == F_ACC) begin
						s_nxt.acc = (s_r.acc & ~m) | r;
						cy = `ALU_CYC_UN_A;
					end else begin
						s_nxt.opnd = (s_r.opnd & ~m) | r;
						cy = `ALU_CYC_UN_R;
					end
				end
				OP_NORM: begin
					s_nxt.flg.z = (s_r.acc == 32'h0);
					if (s_r.acc == 32'h0) begin
						s_nxt.shcnt = 8'h0;
						cy = `ALU_CYC_NRM_Z;
					end else begin
						s_nxt.acc = s_r.acc << lead0(s_r.acc);
						s_nxt.shcnt = {2'h0, lead0(s_r.acc)};
						cy = `ALU_CYC_NRM_B + lead0(s_r.acc);
					end
				end
				// undefined codes cost one cycle and change nothing
				default: cy = 6'd1;
			endcase
			s_nxt.cyc = cy;
			s_nxt.busy = 1'b1;
			s_nxt.cnt = cy - 6'd1;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s_r <= '0;
			s_r.waitreq <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign AVS_READDATA_O = s_r.rdata;
	assign AVS_WAITREQUEST_O = s_r.waitreq;
	assign BUSY_O = s_r.busy;

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	logic [5:0] h_len;
	logic       h_dw;
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			h_len <= 6'h0;
			h_dw <= 1'b0;
		end else if (launch) begin
			h_len <= 6'h0;
			h_dw <= lcmd.op == OP_QUOT_WIDE && s_r.opnd[15:0] != 16'h0
				&& s_r.acc[31:16] < s_r.opnd[15:0]
				&& s_r.acc >= {16'h0, s_r.opnd[15:0]};
		end else if (s_r.busy) begin
			h_len <= h_len + 6'h1;
		end
	end

	property p_step_carry;
		launch && (lcmd.op == OP_ADD_ONE || lcmd.op == OP_SUB_ONE)
			|=> s_r.flg.c == $past(s_r.flg.c) && s_r.busy;
	endproperty
	a_step_carry: assert property (p_step_carry)
		else $error("step op changed carry");
	property p_long_step;
		launch && lcmd.op == OP_ADD_ONE && lcmd.width == W_LONG &&
			lcmd.form == F_REG |=> s_r.busy [*7] ##1 !s_r.busy;
	endproperty
	a_long_step: assert property (p_long_step)
		else $error("long step not 7 cycles");
	property p_cmp_nowrite;
		launch && lcmd.op == OP_COMPARE
			|=> s_r.acc == $past(s_r.acc) && s_r.opnd == $past(s_r.opnd);
	endproperty
	a_cmp_nowrite: assert property (p_cmp_nowrite)
		else $error("compare wrote a result");
	property p_quot_flags;
		launch && lcmd.op == OP_QUOT |=> s_r.flg.n == $past(s_r.flg.n)
			&& s_r.flg.z == $past(s_r.flg.z);
	endproperty
	a_quot_flags: assert property (p_quot_flags)
		else $error("quotient touched n or z");
	property p_quot_div0;
		launch && lcmd.op == OP_QUOT && lcmd.form == F_ACC &&
			s_r.acc[7:0] == 8'h0 |=> s_r.flg.v ##0 s_r.busy [*7]
			##1 !s_r.busy;
	endproperty
	a_quot_div0: assert property (p_quot_div0)
		else $error("accumulator overflow quotient not 7 cycles");
	property p_quotr_div0;
		launch && lcmd.op == OP_QUOT && lcmd.form == F_REG &&
			s_r.opnd[7:0] == 8'h0 |=> s_r.busy [*8] ##1 !s_r.busy;
	endproperty
	a_quotr_div0: assert property (p_quotr_div0)
		else $error("register overflow quotient not 8 cycles");
	property p_wide_len;
		$fell(s_r.busy) && h_dw |-> h_len == 6'd22;
	endproperty
	a_wide_len: assert property (p_wide_len)
		else $error("wide quotient not 22 cycles");
	property p_prodw_zero;
		launch && lcmd.op == OP_PROD_WIDE && lcmd.form == F_ACC &&
			s_r.acc[31:16] == 16'h0 |=> s_r.acc == 32'h0 ##0
			s_r.busy [*3] ##1 !s_r.busy;
	endproperty
	a_prodw_zero: assert property (p_prodw_zero)
		else $error("zero wide product wrong");
	property p_logic_flags;
		launch && (lcmd.op == OP_AND || lcmd.op == OP_XOR ||
			lcmd.op == OP_OR) |=> !s_r.flg.v &&
			s_r.flg.c == $past(s_r.flg.c);
	endproperty
	a_logic_flags: assert property (p_logic_flags)
		else $error("logic op flags wrong");
	property p_norm;
		launch && lcmd.op == OP_NORM && s_r.acc != 32'h0
			|=> s_r.acc[31] && s_r.acc == $past(s_r.acc) << s_r.shcnt;
	endproperty
	a_norm: assert property (p_norm)
		else $error("normalize result wrong");

	c_quot: cover property (launch && lcmd.op == OP_QUOT);
	c_norm: cover property (launch && lcmd.op == OP_NORM &&
		s_r.acc[31:28] == 4'h0);
	c_prodw: cover property (launch && lcmd.op == OP_PROD_WIDE);
	c_read: cover property (req.rd && !s_r.waitreq);
endmodule : alu_datapath

// ==== tb/alu_seq_model.sv ====
// sequencer-side model: one avalon-mm access at a time on the register bus
`timescale 1ns/1ps
module alu_seq_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic        waitreq_i,
	output logic      [4:0]  addr_o,
	output logic             read_o,
	output logic             write_o,
	output logic      [31:0] wdata_o,
	output logic      [3:0]  be_o,
	output logic             tmo_o
);
	initial begin
		addr_o = 5'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		wdata_o = 32'h0000_0000;
		be_o = 4'h0;
		tmo_o = 1'b0;
	end

	// base counts only
	// commands carry no addressing mode, so those cycles stay on this side
	task automatic xfer(input logic we, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q, output int w);
		w = 0;
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		be_o <= be;
		write_o <= we;
		read_o <= !we;
		do begin
			@(posedge clk_i);
			w++;
		end while (waitreq_i !== 1'b0 && w < 200);
		q = rdata_i;
		if (waitreq_i !== 1'b0)
			tmo_o <= 1'b1;
		write_o <= 1'b0;
		read_o <= 1'b0;
		// released lines must not keep looking valid
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : xfer
endmodule : alu_seq_model

// ==== tb/alu_datapath_tb_top.sv ====
// self-checking bench for the arithmetic/logic datapath
`timescale 1ns/1ps
`include "alu_defines.svh"
module alu_datapath_tb_top
	import alu_pkg::*;
;
	logic        clk;
	logic        rst;
	logic        rd;
	logic        wr;
	logic        wq;
	logic        busy;
	logic        tmo;
	logic [4:0]  adr;
	logic [31:0] wd;
	logic [31:0] rdd;
	logic [3:0]  be;
	int          errors;
	int          checks;

	alu_datapath DUT (.SYS_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
		.AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdd),
		.AVS_WAITREQUEST_O(wq), .BUSY_O(busy));
	alu_seq_model seq (.clk_i(clk), .rdata_i(rdd), .waitreq_i(wq),
		.addr_o(adr), .read_o(rd), .write_o(wr), .wdata_o(wd), .be_o(be),
		.tmo_o(tmo));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic results();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	always @(posedge tmo) begin
		errors++;
		results();
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wrr(input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] m = 4'hf);
		logic [31:0] q;
		int          w;
		seq.xfer(1'b1, a, d, m, q, w);
	endtask : wrr

	task automatic rdr(input logic [4:0] a, output logic [31:0] q);
		int w;
		seq.xfer(1'b0, a, 32'h0, 4'hf, q, w);
	endtask : rdr

	function automatic logic [7:0] cm(alu_op_type o, alu_width_type w,
		alu_form_type f);
		return {f, w, o};
	endfunction : cm

	// load, launch, time the busy window, then read back acc, operand, flags and status
	task automatic op(input logic [7:0] c, input logic [31:0] a, o,
		input logic [3:0] f, input logic [5:0] n,
		input logic [31:0] ea, eo, input logic [3:0] ef);
		logic [31:0] q;
		int          k;
		wrr(`ALU_OFS_ACC, a);
		wrr(`ALU_OFS_OPND, o);
		wrr(`ALU_OFS_FLAGS, {28'h0, f});
		wrr(`ALU_OFS_CMD, {24'h0, c});
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (busy !== 1'b1)
				break;
		end
		if (k == 60) begin
			$display("ERROR busy window expected %0d seen over 60", n);
			errors++;
			results();
		end
		chk("busy cycles", {26'h0, n}, k);
		rdr(`ALU_OFS_ACC, q);
		chk("acc", ea, q);
		rdr(`ALU_OFS_OPND, q);
		chk("operand", eo, q);
		rdr(`ALU_OFS_FLAGS, q);
		chk("flags", {28'h0, ef}, q);
		rdr(`ALU_OFS_STAT, q);
		chk("status", {18'h0, n, 8'h0}, q);
	endtask : op

	task automatic t_bus();
		logic [31:0] q;
		int          w;
		for (int i = 0; i < 6; i++) begin
			rdr(5'(i * 4), q);
			chk("reset value", 32'h0, q);
		end
		wrr(5'h18, 32'h5a5a_5a5a);
		rdr(5'h18, q);
		chk("unmapped", 32'h0, q);
		wrr(`ALU_OFS_ACC, 32'hffff_ffff);
		wrr(`ALU_OFS_ACC, 32'h0, 4'h5);
		rdr(`ALU_OFS_ACC, q);
		chk("lane merge", 32'hff00_ff00, q);
		wrr(`ALU_OFS_ACC, 32'h0001_0000);
		wrr(`ALU_OFS_OPND, 32'h3);
		wrr(`ALU_OFS_CMD, {24'h0, cm(OP_QUOT_WIDE, W_WORD, F_REG)});
		seq.xfer(1'b0, `ALU_OFS_STAT, 32'h0, 4'hf, q, w);
		chk("stalled read", {18'h0, 6'd22, 8'h0}, q);
		chk("stall length", 32'h1, 32'(w > 22));
		// undefined command: one cycle, nothing changes
		op(8'h0d, 32'h1, 32'h2, 4'h5, 1, 32'h1, 32'h2, 4'h5);
	endtask : t_bus

	task automatic t_incdec();
		op(cm(OP_ADD_ONE, W_BYTE, F_REG), 32'h0, 32'h1234_56ff, 4'h1, 2,
			32'h0, 32'h1234_5600, 4'h5);
		op(cm(OP_SUB_ONE, W_BYTE, F_REG), 32'h0, 32'h1234_5600, 4'h1, 3,
			32'h0, 32'h1234_56ff, 4'h9);
		op(cm(OP_SUB_ONE, W_WORD, F_REG), 32'h0, 32'habcd_8000, 4'h0, 3,
			32'h0, 32'habcd_7fff, 4'h2);
		op(cm(OP_ADD_ONE, W_BYTE, F_ACC), 32'h1234_567f, 32'h0, 4'h0, 2,
			32'h1234_5680, 32'h0, 4'ha);
		op(cm(OP_ADD_ONE, W_LONG, F_REG), 32'h0, 32'h7fff_ffff, 4'h0, 7,
			32'h0, 32'h8000_0000, 4'ha);
		op(cm(OP_SUB_ONE, W_LONG, F_REG), 32'h0, 32'h0, 4'h1, 7,
			32'h0, 32'hffff_ffff, 4'h9);
	endtask : t_incdec

	task automatic t_compare();
		op(cm(OP_COMPARE, W_WORD, F_REG), 32'h1111_0003, 32'h5, 4'h0, 2,
			32'h1111_0003, 32'h5, 4'h9);
		op(cm(OP_COMPARE, W_LONG, F_REG), 32'h8000_0000, 32'h1, 4'h0, 6,
			32'h8000_0000, 32'h1, 4'h2);
		op(cm(OP_COMPARE, W_BYTE, F_ACC), 32'h0005_0005, 32'h0, 4'h0, 1,
			32'h0005_0005, 32'h0, 4'h4);
		op(cm(OP_COMPARE, W_WORD, F_ACC), 32'h0003_0005, 32'h0, 4'h0, 1,
			32'h0003_0005, 32'h0, 4'h9);
	endtask : t_compare

	task automatic t_quot();
		op(cm(OP_QUOT, W_BYTE, F_ACC), 32'h0064_0007, 32'h0, 4'hf, 15,
			32'h0064_020e, 32'h0, 4'hc);
		op(cm(OP_QUOT, W_BYTE, F_ACC), 32'h0003_0007, 32'h0, 4'hf, 3,
			32'h0003_0300, 32'h0, 4'hc);
		op(cm(OP_QUOT, W_BYTE, F_ACC), 32'h0800_0002, 32'h0, 4'h0, 7,
			32'h0800_0002, 32'h0, 4'h2);
		op(cm(OP_QUOT, W_BYTE, F_ACC), 32'h0012_0000, 32'h0, 4'h0, 7,
			32'h0012_0000, 32'h0, 4'h3);
		op(cm(OP_QUOT, W_BYTE, F_REG), 32'h0064, 32'h7, 4'h0, 16,
			32'h000e, 32'h2, 4'h0);
		op(cm(OP_QUOT, W_BYTE, F_REG), 32'h0064, 32'h0, 4'h0, 8,
			32'h0064, 32'h0, 4'h3);
		op(cm(OP_QUOT_WIDE, W_WORD, F_REG), 32'h0001_0000, 32'h3, 4'h0, 22,
			32'h5555, 32'h1, 4'h0);
		op(cm(OP_QUOT_WIDE, W_WORD, F_REG), 32'h2, 32'h5, 4'h0, 4,
			32'h0, 32'h2, 4'h0);
		op(cm(OP_QUOT_WIDE, W_WORD, F_REG), 32'h0005_0000, 32'h2, 4'h0, 7,
			32'h0005_0000, 32'h2, 4'h2);
	endtask : t_quot

	task automatic t_prod();
		op(cm(OP_PROD, W_BYTE, F_ACC), 32'h00ff_00ff, 32'h0, 4'hf, 7,
			32'h00ff_fe01, 32'h0, 4'hf);
		op(cm(OP_PROD, W_BYTE, F_ACC), 32'h0000_00ff, 32'h0, 4'h0, 3,
			32'h0, 32'h0, 4'h0);
		op(cm(OP_PROD, W_BYTE, F_REG), 32'h0010, 32'h10, 4'h6, 8,
			32'h0100, 32'h10, 4'h6);
		op(cm(OP_PROD_WIDE, W_WORD, F_ACC), 32'hffff_ffff, 32'h0, 4'h5, 11,
			32'hfffe_0001, 32'h0, 4'h5);
		op(cm(OP_PROD_WIDE, W_WORD, F_ACC), 32'h1234, 32'h0, 4'ha, 3,
			32'h0, 32'h0, 4'ha);
		op(cm(OP_PROD_WIDE, W_WORD, F_REG), 32'h0100, 32'h0100, 4'h9, 12,
			32'h0001_0000, 32'h0100, 4'h9);
		op(cm(OP_PROD_WIDE, W_WORD, F_REG), 32'h5, 32'h0, 4'h6, 4,
			32'h0, 32'h0, 4'h6);
	endtask : t_prod

	task automatic t_logic();
		op(cm(OP_AND, W_WORD, F_ACC), 32'hf0f0_ff00, 32'h0, 4'h3, 2,
			32'hf0f0_f000, 32'h0, 4'h9);
		op(cm(OP_OR, W_WORD, F_ACC), 32'h0, 32'h0, 4'h2, 2,
			32'h0, 32'h0, 4'h4);
		op(cm(OP_XOR, W_WORD, F_ACC), 32'h8001_0001, 32'h0, 4'h0, 2,
			32'h8001_8000, 32'h0, 4'h8);
		op(cm(OP_AND, W_BYTE, F_REG), 32'h1234_56f0, 32'hf, 4'hb, 3,
			32'h1234_5600, 32'hf, 4'h5);
		op(cm(OP_XOR, W_BYTE, F_MEM), 32'hff, 32'haaaa_aa0f, 4'h0, 3,
			32'hff, 32'haaaa_aaf0, 4'h8);
		op(cm(OP_AND, W_LONG, F_REG), 32'hffff_0000, 32'h8000_ffff, 4'h2, 6,
			32'h8000_0000, 32'h8000_ffff, 4'h8);
		op(cm(OP_OR, W_LONG, F_REG), 32'h1, 32'h8000_0000, 4'h0, 6,
			32'h8000_0001, 32'h8000_0000, 4'h8);
		op(cm(OP_XOR, W_LONG, F_REG), 32'h1234_5678, 32'h1234_5678, 4'h3, 6,
			32'h0, 32'h1234_5678, 4'h5);
	endtask : t_logic

	task automatic t_unary();
		op(cm(OP_INVERT, W_BYTE, F_ACC), 32'h1234_56ff, 32'h0, 4'h2, 2,
			32'h1234_5600, 32'h0, 4'h4);
		op(cm(OP_INVERT, W_WORD, F_REG), 32'h0, 32'hffff_0f0f, 4'h3, 3,
			32'h0, 32'hffff_f0f0, 4'h9);
		op(cm(OP_TWOS, W_BYTE, F_ACC), 32'h80, 32'h0, 4'h0, 2,
			32'h80, 32'h0, 4'hb);
		op(cm(OP_TWOS, W_WORD, F_REG), 32'h0, 32'h1, 4'h0, 3,
			32'h0, 32'hffff, 4'h9);
		op(cm(OP_TWOS, W_BYTE, F_ACC), 32'h0, 32'h0, 4'hf, 2,
			32'h0, 32'h0, 4'h4);
	endtask : t_unary

	task automatic t_norm();
		logic [31:0] q;
		wrr(`ALU_OFS_SHCNT, 32'hff);
		op(cm(OP_NORM, W_LONG, F_ACC), 32'h0001_0000, 32'h0, 4'hf, 21,
			32'h8000_0000, 32'h0, 4'hb);
		rdr(`ALU_OFS_SHCNT, q);
		chk("shift count", 32'd15, q);
		op(cm(OP_NORM, W_LONG, F_ACC), 32'h8000_0000, 32'h0, 4'h0, 6,
			32'h8000_0000, 32'h0, 4'h0);
		wrr(`ALU_OFS_SHCNT, 32'hff);
		op(cm(OP_NORM, W_LONG, F_ACC), 32'h0, 32'h0, 4'h8, 4,
			32'h0, 32'h0, 4'hc);
		rdr(`ALU_OFS_SHCNT, q);
		chk("shift count", 32'h0, q);
	endtask : t_norm

	initial begin
		rst = 1'b1;
		errors = 0;
		checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_bus();
		t_incdec();
		t_compare();
		t_quot();
		t_prod();
		t_logic();
		t_unary();
		t_norm();
		results();
	end
endmodule : alu_datapath_tb_top
